// file: core/cmp_ctrl_defs.vh
// Purpose: register map, field positions, reset values and timing counts
//          for the analog comparator control block
// Assumes: 10 MHz clock on aclk, 32-bit AXI4-Lite data, byte addresses
// Notes:   all offsets are byte addresses of aligned 32-bit words
`ifndef CMP_CTRL_DEFS_VH
`define CMP_CTRL_DEFS_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define ADDR_W 8
`define CTL1_ADDR 8'hAC
`define CTL2_ADDR 8'hB0
`define INBUF_OFF_ADDR 8'hB4
`define IRQ_STATUS_ADDR 8'hB8
`define IRQ_ENABLE_ADDR 8'hBC

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTL_ON_BIT 5
`define CTL_POS_BIT 4
`define CTL_NEG_BIT 3
`define CTL_PIN_BIT 2
`define CTL_SYNC_BIT 1
`define CTL_FLAG_BIT 0
`define CTL_WR_MASK 8'h3C
`define CTL_RESET 8'h00

// ----------------------------------------------------------------------
// interrupt status / enable fields
// ----------------------------------------------------------------------
`define IRQ_ONE_BIT 0
`define IRQ_TWO_BIT 1
`define IRQ_GLOBAL_BIT 7
`define IRQ_EN_WR_MASK 8'h83
`define IRQ_EN_RESET 8'h00
`define INBUF_OFF_RESET 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define SETTLE_NS 10000
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: core/cmp_channel.v
// Purpose: one comparator: input muxing, pin output, clock-domain
//          synchronizer, settling window and change detection
// Assumes: analog levels arrive as unsigned codes from the front end
// Notes:   HAS_POS_A = 0 models a comparator with no first positive pin
module cmp_channel #(
    parameter LEVEL_W = 8,
    parameter SETTLE_CYC = 100,
    parameter CNT_W = 7,
    parameter HAS_POS_A = 1
)(
    input wire aclk, // block clock
    input wire aresetn, // synchronous reset, active low
    input wire comparator_on, // enable field
    input wire positive_input_select, // 0: pin a, 1: pin b
    input wire negative_input_select, // 0: reference pin, 1: internal ref
    input wire result_pin_enable, // route result to output pin
    input wire [LEVEL_W-1:0] pos_a_lvl, // first positive pin level
    input wire [LEVEL_W-1:0] pos_b_lvl, // second positive pin level
    input wire [LEVEL_W-1:0] ref_pin_lvl, // reference pin level
    input wire [LEVEL_W-1:0] ref_int_lvl, // internal reference level
    output wire result_pin_o, // unsynchronized result to pin
    output wire result_pin_oe, // pin driven while routed
    output wire synced_result, // result on aclk, zero when off
    output wire change_evt // one-cycle pulse on valid change
);
    localparam [CNT_W-1:0] SETTLE_LOAD = SETTLE_CYC[CNT_W-1:0];

    reg sync1_r;
    reg sync2_r;
    reg synced_r;
    reg on_d_r;
    reg valid_d_r;
    reg [CNT_W-1:0] settle_r;
    wire pos_ok;
    wire [LEVEL_W-1:0] pos_lvl;
    wire [LEVEL_W-1:0] neg_lvl;
    wire raw;
    wire valid;

    // ------------------------------------------------------------------
    // comparison
    // ------------------------------------------------------------------
    assign pos_ok = positive_input_select | (HAS_POS_A != 0);
    assign pos_lvl = positive_input_select ? pos_b_lvl : pos_a_lvl;
    assign neg_lvl = negative_input_select ? ref_int_lvl : ref_pin_lvl;
    assign raw = pos_ok & (pos_lvl > neg_lvl);

    // the pin path is deliberately not clocked so it still works with
    // the clock stopped
    assign result_pin_oe = comparator_on & result_pin_enable;
    assign result_pin_o = result_pin_oe & raw;

    // ------------------------------------------------------------------
    // synchronizer, settling window, change detection
    // ------------------------------------------------------------------
    assign valid = comparator_on & on_d_r & (settle_r == {CNT_W{1'b0}});
    assign synced_result = synced_r;
    // both this and the previous cycle must be valid, so the first
    // sample after settling never counts as a change
    assign change_evt = valid & valid_d_r & (sync2_r != synced_r);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            synced_r <= 1'b0;
            on_d_r <= 1'b0;
            valid_d_r <= 1'b0;
            settle_r <= {CNT_W{1'b0}};
        end
        else
        begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
            on_d_r <= comparator_on;
            valid_d_r <= valid;
            if (!comparator_on)
                settle_r <= {CNT_W{1'b0}};
            else if (!on_d_r)
                settle_r <= SETTLE_LOAD;
            else if (settle_r != {CNT_W{1'b0}})
                settle_r <= settle_r - {{(CNT_W-1){1'b0}}, 1'b1};
            synced_r <= valid ? sync2_r : 1'b0;
        end
    end
endmodule

// file: core/cmp_ctrl.v
// Purpose: control and status for two analog comparators and the port 0
//          digital input disable, reached over AXI4-Lite
// Assumes: 10 MHz aclk; analog levels and port pins are asynchronous
// Notes:   one write and one read in flight; registers are 8 bits wide
//
// Functional notes
// - one input-disable bit per port 0 pin
// - disabled port pins read as zero
// - result high only when positive exceeds negative
// - positive from two pins, negative pin or internal
// - control fields pick eight or four configurations
// - output and flag invalid 10 us after enable
// - bit 5 enables the comparator
// - bit 4 selects the positive input pin
// - bit 3 selects reference pin or internal reference
// - bit 2 routes raw result to pin
// - bit 1 synced result, zero when disabled
// - bit 0 flag set on synced result change
// - interrupt needs comparator enable and global enable
// - comparators and wake-up work in low power
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "cmp_ctrl_defs.vh"

module cmp_ctrl #(
    parameter LEVEL_W = 8,
    parameter SETTLE_CYC = `SETTLE_CYCLES,
    parameter CNT_W = 7
)(
    input wire aclk, // block clock, 10 MHz
    input wire aresetn, // synchronous reset, active low
    input wire [`ADDR_W-1:0] awaddr, // write address
    input wire awvalid, // write address valid
    output wire awready, // write address ready
    input wire [31:0] wdata, // write data
    input wire [3:0] wstrb, // write byte strobes
    input wire wvalid, // write data valid
    output wire wready, // write data ready
    output wire [1:0] bresp, // write response
    output wire bvalid, // write response valid
    input wire bready, // write response ready
    input wire [`ADDR_W-1:0] araddr, // read address
    input wire arvalid, // read address valid
    output wire arready, // read address ready
    output wire [31:0] rdata, // read data
    output wire [1:0] rresp, // read response
    output wire rvalid, // read data valid
    input wire rready, // read data ready
    input wire [LEVEL_W-1:0] cin1a_lvl, // comparator 1 positive pin a
    input wire [LEVEL_W-1:0] cin1b_lvl, // comparator 1 positive pin b
    input wire [LEVEL_W-1:0] cin2b_lvl, // comparator 2 positive pin b
    input wire [LEVEL_W-1:0] reference_pin_lvl, // shared reference pin
    input wire [LEVEL_W-1:0] vref_lvl, // internal reference level
    input wire [7:0] port0_pin_i, // port 0 pin levels
    output wire [7:0] port0_read_o, // port 0 value seen by software
    output wire [7:0] port_input_buffer_off, // per-pin buffer disable
    output wire res1_pin_o, // comparator 1 result pin
    output wire res1_pin_oe, // comparator 1 pin enable
    output wire res2_pin_o, // comparator 2 result pin
    output wire res2_pin_oe, // comparator 2 pin enable
    output wire irq // level interrupt, also wake request
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function addr_mapped;
        input [`ADDR_W-1:0] a;
        begin
            addr_mapped = (a == `CTL1_ADDR) || (a == `CTL2_ADDR) ||
                (a == `INBUF_OFF_ADDR) || (a == `IRQ_STATUS_ADDR) ||
                (a == `IRQ_ENABLE_ADDR);
        end
    endfunction

    function [7:0] ctl_view;
        input [7:0] ctl;
        input synced;
        input flag;
        begin
            ctl_view = (ctl & `CTL_WR_MASK) |
                ({7'h00, synced} << `CTL_SYNC_BIT) |
                ({7'h00, flag} << `CTL_FLAG_BIT);
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg aw_full_r;
    reg [`ADDR_W-1:0] aw_addr_r;
    reg w_full_r;
    reg [7:0] w_data_r;
    reg w_strb_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [7:0] rdata_r;
    reg [1:0] rresp_r;
    reg [7:0] ctl1_r;
    reg [7:0] ctl2_r;
    reg [7:0] inbuf_off_r;
    reg [7:0] irq_en_r;
    reg [1:0] flag_r;
    reg [1:0] flag_nxt;
    reg [7:0] p0_sync1_r;
    reg [7:0] p0_sync2_r;
    reg [7:0] port0_read_r;
    reg [7:0] read_mux;
    wire do_wr;
    wire wr_hit;
    wire [1:0] evt;
    wire [1:0] synced;
    wire [1:0] pending;

    // ------------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------------
    cmp_channel #(
        .LEVEL_W(LEVEL_W),
        .SETTLE_CYC(SETTLE_CYC),
        .CNT_W(CNT_W),
        .HAS_POS_A(1)
    ) u_ch1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .comparator_on(ctl1_r[`CTL_ON_BIT]),
        .positive_input_select(ctl1_r[`CTL_POS_BIT]),
        .negative_input_select(ctl1_r[`CTL_NEG_BIT]),
        .result_pin_enable(ctl1_r[`CTL_PIN_BIT]),
        .pos_a_lvl(cin1a_lvl),
        .pos_b_lvl(cin1b_lvl),
        .ref_pin_lvl(reference_pin_lvl),
        .ref_int_lvl(vref_lvl),
        .result_pin_o(res1_pin_o),
        .result_pin_oe(res1_pin_oe),
        .synced_result(synced[0]),
        .change_evt(evt[0])
    );

    // the second comparator has no first positive pin: with the select
    // bit low its positive input is absent and its result stays low
    cmp_channel #(
        .LEVEL_W(LEVEL_W),
        .SETTLE_CYC(SETTLE_CYC),
        .CNT_W(CNT_W),
        .HAS_POS_A(0)
    ) u_ch2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .comparator_on(ctl2_r[`CTL_ON_BIT]),
        .positive_input_select(ctl2_r[`CTL_POS_BIT]),
        .negative_input_select(ctl2_r[`CTL_NEG_BIT]),
        .result_pin_enable(ctl2_r[`CTL_PIN_BIT]),
        .pos_a_lvl({LEVEL_W{1'b0}}),
        .pos_b_lvl(cin2b_lvl),
        .ref_pin_lvl(reference_pin_lvl),
        .ref_int_lvl(vref_lvl),
        .result_pin_o(res2_pin_o),
        .result_pin_oe(res2_pin_oe),
        .synced_result(synced[1]),
        .change_evt(evt[1])
    );

    // ------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------
    // no idle or power-down input gates anything here, so enabled
    // comparators and this request keep running in low-power modes
    assign pending = flag_r & irq_en_r[`IRQ_TWO_BIT:`IRQ_ONE_BIT];
    assign irq = irq_en_r[`IRQ_GLOBAL_BIT] & (|pending);

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign awready = ~aw_full_r;
    assign wready = ~w_full_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign do_wr = aw_full_r & w_full_r & ~bvalid_r;
    assign wr_hit = do_wr & w_strb_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            aw_addr_r <= {`ADDR_W{1'b0}};
            w_full_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end
        else
        begin
            if (awvalid && !aw_full_r)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && !w_full_r)
            begin
                w_full_r <= 1'b1;
                w_data_r <= wdata[7:0];
                w_strb_r <= wstrb[0];
            end
            if (do_wr)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= addr_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid_r && bready)
                bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registers and change flags
    // ------------------------------------------------------------------
    // a change in the same cycle as a clear wins, so no event is lost
    always @*
    begin
        flag_nxt = flag_r;
        if (wr_hit && aw_addr_r == `CTL1_ADDR && !w_data_r[`CTL_FLAG_BIT])
            flag_nxt[0] = 1'b0;
        if (wr_hit && aw_addr_r == `CTL2_ADDR && !w_data_r[`CTL_FLAG_BIT])
            flag_nxt[1] = 1'b0;
        if (wr_hit && aw_addr_r == `IRQ_STATUS_ADDR)
            flag_nxt = flag_nxt & ~w_data_r[`IRQ_TWO_BIT:`IRQ_ONE_BIT];
        flag_nxt = flag_nxt | evt;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl1_r <= `CTL_RESET;
            ctl2_r <= `CTL_RESET;
            inbuf_off_r <= `INBUF_OFF_RESET;
            irq_en_r <= `IRQ_EN_RESET;
            flag_r <= 2'b00;
        end
        else
        begin
            flag_r <= flag_nxt;
            if (wr_hit)
            begin
                if (aw_addr_r == `CTL1_ADDR)
                    ctl1_r <= w_data_r & `CTL_WR_MASK;
                else if (aw_addr_r == `CTL2_ADDR)
                    ctl2_r <= w_data_r & `CTL_WR_MASK;
                else if (aw_addr_r == `INBUF_OFF_ADDR)
                    inbuf_off_r <= w_data_r;
                else if (aw_addr_r == `IRQ_ENABLE_ADDR)
                    irq_en_r <= w_data_r & `IRQ_EN_WR_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // port 0 input path
    // ------------------------------------------------------------------
    assign port_input_buffer_off = inbuf_off_r;
    assign port0_read_o = port0_read_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            p0_sync1_r <= 8'h00;
            p0_sync2_r <= 8'h00;
            port0_read_r <= 8'h00;
        end
        else
        begin
            p0_sync1_r <= port0_pin_i;
            p0_sync2_r <= p0_sync1_r;
            port0_read_r <= p0_sync2_r & ~inbuf_off_r;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign arready = ~rvalid_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = {24'h000000, rdata_r};

    always @*
    begin
        read_mux = 8'h00;
        if (araddr == `CTL1_ADDR)
            read_mux = ctl_view(ctl1_r, synced[0], flag_r[0]);
        else if (araddr == `CTL2_ADDR)
            read_mux = ctl_view(ctl2_r, synced[1], flag_r[1]);
        else if (araddr == `INBUF_OFF_ADDR)
            read_mux = inbuf_off_r;
        else if (araddr == `IRQ_STATUS_ADDR)
            read_mux = {6'h00, flag_r};
        else if (araddr == `IRQ_ENABLE_ADDR)
            read_mux = irq_en_r;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
            rresp_r <= `RESP_OKAY;
        end
        else
        begin
            if (arvalid && !rvalid_r)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= read_mux;
                rresp_r <= addr_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (rvalid_r && rready)
                rvalid_r <= 1'b0;
        end
    end

endmodule

// file: dv/analog_far_side.sv
// Purpose: far-side model of the analog inputs and the port 0 pins
// Assumes: levels change only just after a rising aclk edge
// Notes:   the internal reference level is supplied here as well
module analog_far_side #(
    parameter LEVEL_W = 8
)(
    input logic aclk, // block clock
    output logic [LEVEL_W-1:0] pin_a, // comparator 1 pin a
    output logic [LEVEL_W-1:0] pin_b, // comparator 1 pin b
    output logic [LEVEL_W-1:0] pin_2b, // comparator 2 pin b
    output logic [LEVEL_W-1:0] ref_pin, // reference pin
    output logic [LEVEL_W-1:0] vref, // internal reference
    output logic [7:0] port_pins // port 0 pins, always driven
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {pin_a, pin_b, pin_2b, ref_pin, vref, port_pins} = '0;
    end
    task automatic set_levels(input logic [LEVEL_W-1:0] a, b, b2, r, v);
        @(posedge aclk);
        {pin_a, pin_b, pin_2b, ref_pin, vref} <= {a, b, b2, r, v};
    endtask
    task automatic set_pins(input logic [7:0] p);
        @(posedge aclk);
        port_pins <= p;
    endtask
endmodule

// file: dv/cmp_ctrl_properties.sv
// Purpose: port-level checks of the comparator control block
// Assumes: master never overlaps two writes or two reads
// Notes:   register contents are not visible here, only pin relations
module cmp_ctrl_props #(
    parameter LEVEL_W = 8
)(
    input logic aclk, // clock
    input logic aresetn, // reset, active low
    input logic awvalid, // aw valid
    input logic awready, // aw ready
    input logic wvalid, // w valid
    input logic wready, // w ready
    input logic [1:0] bresp, // b code
    input logic bvalid, // b valid
    input logic bready, // b ready
    input logic arvalid, // ar valid
    input logic arready, // ar ready
    input logic rvalid, // r valid
    input logic rready, // r ready
    input logic [LEVEL_W-1:0] cin1a_lvl, // pin a
    input logic [LEVEL_W-1:0] cin1b_lvl, // pin b
    input logic [LEVEL_W-1:0] cin2b_lvl, // pin 2b
    input logic [LEVEL_W-1:0] reference_pin_lvl, // ref pin
    input logic [LEVEL_W-1:0] vref_lvl, // internal ref
    input logic [7:0] port0_pin_i, // port pins
    input logic [7:0] port0_read_o, // port read
    input logic [7:0] port_input_buffer_off, // disables
    input logic res1_pin_o, // result pin 1
    input logic res1_pin_oe, // enable 1
    input logic res2_pin_o, // result pin 2
    input logic res2_pin_oe, // enable 2
    input logic irq // interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire [LEVEL_W-1:0] lo = (reference_pin_lvl < vref_lvl) ? reference_pin_lvl : vref_lvl;
    wire [LEVEL_W-1:0] hi = (reference_pin_lvl < vref_lvl) ? vref_lvl : reference_pin_lvl;
    a_pin_gated_one: assert property (!res1_pin_oe |-> !res1_pin_o) else $error("pin1 not gated");
    a_pin_gated_two: assert property (!res2_pin_oe |-> !res2_pin_o) else $error("pin2 not gated");
    a_pin_high_one: assert property (res1_pin_oe && cin1a_lvl > hi && cin1b_lvl > hi
        |-> res1_pin_o) else $error("pin1 low");
    a_pin_low_one: assert property (res1_pin_oe && cin1a_lvl <= lo && cin1b_lvl <= lo
        |-> !res1_pin_o) else $error("pin1 high");
    a_pin_low_two: assert property (res2_pin_oe && cin2b_lvl <= lo |-> !res2_pin_o)
        else $error("pin2 high");
    a_port_masked: assert property ((port0_read_o & port_input_buffer_off
        & $past(port_input_buffer_off)) == 8'h00) else $error("disabled bit read");
    a_port_follows: assert property (($stable(port0_pin_i)
        && $stable(port_input_buffer_off)) [*4]
        |-> port0_read_o == (port0_pin_i & ~port_input_buffer_off)) else $error("port read");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:4] bvalid)
        else $error("no write answer");
    a_bvalid_drop: assert property (bvalid && bready |=> !bvalid) else $error("b stuck");
    a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
    a_read_busy: assert property (rvalid |-> !arready) else $error("ar open while r held");
    c_pin_high: cover property (res1_pin_oe && res1_pin_o);
    c_irq: cover property (irq);
    c_port: cover property (port0_read_o != 8'h00);
    c_slverr: cover property (bvalid && bresp == 2'b10);
endmodule

bind cmp_ctrl cmp_ctrl_props #(.LEVEL_W(LEVEL_W)) props_i (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .cin1a_lvl(cin1a_lvl), .cin1b_lvl(cin1b_lvl), .cin2b_lvl(cin2b_lvl),
    .reference_pin_lvl(reference_pin_lvl), .vref_lvl(vref_lvl), .port0_pin_i(port0_pin_i),
    .port0_read_o(port0_read_o), .port_input_buffer_off(port_input_buffer_off),
    .res1_pin_o(res1_pin_o), .res1_pin_oe(res1_pin_oe), .res2_pin_o(res2_pin_o),
    .res2_pin_oe(res2_pin_oe), .irq(irq));

// file: dv/tb_top.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: settle window shortened to 8 cycles
// Notes:   analog levels are random codes with a few fixed corners
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] a1, b1, b2, rp, vr, pins, prd, poff;
    wire [1:0] po, poe;
    logic [7:0] la, lb, l2, lr, lv, cfg;
    logic [7:0] regs [5] = '{8'hAC, 8'hB0, 8'hB4, 8'hB8, 8'hBC};
    logic [31:0] r, x, seed = 32'hCF511731;
    int error_cnt = 0, comparisons = 0;
    always #50 aclk = ~aclk;
    analog_far_side #(.LEVEL_W(8)) far (.aclk(aclk), .pin_a(a1), .pin_b(b1), .pin_2b(b2),
        .ref_pin(rp), .vref(vr), .port_pins(pins));
    cmp_ctrl #(.LEVEL_W(8), .SETTLE_CYC(SC)) DUT (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .cin1a_lvl(a1), .cin1b_lvl(b1), .cin2b_lvl(b2),
        .reference_pin_lvl(rp), .vref_lvl(vr), .port0_pin_i(pins), .port0_read_o(prd),
        .port_input_buffer_off(poff), .res1_pin_o(po[0]), .res1_pin_oe(poe[0]),
        .res2_pin_o(po[1]), .res2_pin_oe(poe[1]), .irq(irq));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic exp_res(input int c, input logic [7:0] f);
        logic [7:0] neg;
        neg = f[3] ? lv : lr;
        if (c == 1)
            return (f[4] ? lb : la) > neg;
        return f[4] && (l2 > neg);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
        bit fa, fw, fb;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'b111};
        {fa, fw, fb} = 3'b111;
        while (fb)
        begin
            @(posedge aclk);
            if (!fa && !fw && bvalid)
            begin
                fb = 1'b0;
                bready <= 1'b0;
                chk(bresp, er);
            end
            if (fa && awready)
            begin
                fa = 1'b0;
                awvalid <= 1'b0;
            end
            if (fw && wready)
            begin
                fw = 1'b0;
                wvalid <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
        bit fa, fr;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        {fa, fr} = 2'b11;
        while (fr)
        begin
            @(posedge aclk);
            if (!fa && rvalid)
            begin
                fr = 1'b0;
                rready <= 1'b0;
                d = rdata;
                chk(rresp, er);
            end
            if (fa && arready)
            begin
                fa = 1'b0;
                arvalid <= 1'b0;
            end
        end
    endtask
    task automatic lvl(input logic [7:0] a, b, c2, rf, v);
        {la, lb, l2, lr, lv} = {a, b, c2, rf, v};
        far.set_levels(a, b, c2, rf, v);
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial
    begin
        #1_000_000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i])
        begin
            rd(regs[i], r);
            chk(r, 32'h0);
        end
        rd(8'hC0, r, 2'b10);
        chk(r, 32'h0);
        wr(8'hC0, 8'hFF, 2'b10);
        wstrb <= 4'h0;
        wr(8'hB4, 8'hFF);
        chk(poff, 8'h00);
        wstrb <= 4'hF;
        for (int i = 0; i < 6; i++)
        begin
            x = xs();
            wr(8'hB4, x[7:0]);
            far.set_pins(x[15:8]);
            repeat (5) @(posedge aclk);
            chk(prd, x[15:8] & ~x[7:0]);
            chk(poff, x[7:0]);
            rd(8'hB4, r);
            chk(r, x[7:0]);
        end
        for (int c = 1; c <= 2; c++)
            for (int k = 0; k < 8; k++)
            begin
                cfg = 8'h20 | 8'(k << 2);
                x = (k == 1) ? 32'h55555555 : (k == 5) ? 32'h10E0D0C0 : xs();
                lvl(x[7:0], x[15:8], x[23:16], x[31:24], x[7:0] ^ 8'h80);
                wr(regs[c-1], cfg);
                rd(regs[c-1], r);
                chk(r, cfg);
                repeat (SC + 6) @(posedge aclk);
                rd(regs[c-1], r);
                chk(r, cfg | 8'(exp_res(c, cfg) << 1));
                chk(po[c-1], cfg[2] & exp_res(c, cfg));
                chk(poe[c-1], cfg[2]);
                wr(regs[c-1], 8'h00);
                rd(regs[c-1], r);
                chk(r, 32'h0);
            end
        lvl(8'h10, 8'h10, 8'h10, 8'h80, 8'h80);
        wr(8'hAC, 8'h20);
        repeat (SC + 6) @(posedge aclk);
        wr(8'hAC, 8'h20);
        wr(8'hBC, 8'h81);
        chk(irq, 1'b0);
        lvl(8'hF0, 8'h10, 8'h10, 8'h80, 8'h80);
        repeat (6) @(posedge aclk);
        rd(8'hAC, r);
        chk(r, 32'h23);
        rd(8'hB8, r);
        chk(r, 32'h1);
        chk(irq, 1'b1);
        wr(8'hBC, 8'h01);
        chk(irq, 1'b0);
        wr(8'hBC, 8'h80);
        chk(irq, 1'b0);
        wr(8'hBC, 8'h81);
        wr(8'hAC, 8'h21);
        rd(8'hAC, r);
        chk(r, 32'h23);
        chk(irq, 1'b1);
        wr(8'hAC, 8'h20);
        rd(8'hAC, r);
        chk(r, 32'h22);
        chk(irq, 1'b0);
        lvl(8'h10, 8'h10, 8'h10, 8'h80, 8'h80);
        repeat (6) @(posedge aclk);
        rd(8'hAC, r);
        chk(r, 32'h21);
        wr(8'hB8, 8'h01);
        rd(8'hB8, r);
        chk(r, 32'h0);
        chk(irq, 1'b0);
        wrap_up();
    end
endmodule
